// File: hw/sensor_threshold_alarm_config.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module sensor_threshold_alarm_config
	import alarm_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	input  wire logic [3:0]               pstrb,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Sensor conversion results, same clock
	input  wire logic                     pin0_valid,
	input  wire logic [CODE_W-1:0]        pin0_code,
	input  wire logic                     pin1_valid,
	input  wire logic [CODE_W-1:0]        pin1_code,
	input  wire logic                     temp_valid,
	input  wire logic [CODE_W-1:0]        temp_code,
	// Receive and return path conditions, same clock
	input  wire logic [SERIAL_ALARMS-1:0] serial_cond,
	input  wire logic [RETURN_ALARMS-1:0] return_cond,
	// Alarm outputs
	output logic      [SERIAL_ALARMS-1:0] serial_alarm,
	output logic      [SENSOR_ALARMS-1:0] sensor_alarm,
	output logic      [RETURN_ALARMS-1:0] return_alarm,
	// Lane polarity
	input  wire logic [LANES:0]           hs_lane_in,
	input  wire logic [LANES:0]           lp_lane_in,
	output logic      [LANES:0]           hs_lane_out,
	output logic      [LANES:0]           lp_lane_out
);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] pin0_limits_reg;
	logic [7:0] pin1_limits_reg;
	logic [7:0] temp_limits_reg;
	logic [7:0] serial_mask_reg;
	logic [7:0] sensor_mask_reg;
	logic [7:0] return_mask_reg;
	logic [7:0] hs_pol_reg;
	logic [7:0] lp_pol_reg;
	logic [7:0] sense_ctrl_reg;
	logic [5:0] flags_reg;
	logic [CODE_W-1:0] peak_reg;
	logic [CODE_W-1:0] trough_reg;
	logic [9:0] word_addr;
	logic       wr_en;
	logic       rd_hit;
	logic [7:0] rd_next;

	assign word_addr = paddr[11:2];
	assign wr_en     = psel && penable && pwrite && pstrb[0] && !pslverr;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !rd_hit;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
			input logic [7:0] wm, input logic [7:0] rv);
		merge = (wd & wm) | (rv & ~wm);
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin0_limits_reg <= LIMITS_RST;
			pin1_limits_reg <= LIMITS_RST;
			temp_limits_reg <= LIMITS_RST;
			serial_mask_reg <= SERIAL_MASK_RST;
			sensor_mask_reg <= SENSOR_MASK_RST;
			return_mask_reg <= RETURN_MASK_RST;
			hs_pol_reg      <= POL_RST;
			lp_pol_reg      <= POL_RST;
			sense_ctrl_reg  <= SENSE_CTRL_RST;
		end else if (wr_en) begin
			unique case (word_addr[7:0])
				IDX_PIN0_LIMITS: pin0_limits_reg <= merge(pin0_limits_reg, pwdata[7:0],
					LIMITS_WMASK, LIMITS_RST);
				IDX_PIN1_LIMITS: pin1_limits_reg <= merge(pin1_limits_reg, pwdata[7:0],
					LIMITS_WMASK, LIMITS_RST);
				IDX_TEMP_LIMITS: temp_limits_reg <= merge(temp_limits_reg, pwdata[7:0],
					LIMITS_WMASK, LIMITS_RST);
				IDX_SERIAL_MASK: serial_mask_reg <= merge(serial_mask_reg, pwdata[7:0],
					SERIAL_WMASK, SERIAL_MASK_RST);
				IDX_SENSOR_MASK: sensor_mask_reg <= merge(sensor_mask_reg, pwdata[7:0],
					SENSOR_WMASK, SENSOR_MASK_RST);
				IDX_RETURN_MASK: return_mask_reg <= merge(return_mask_reg, pwdata[7:0],
					RETURN_WMASK, RETURN_MASK_RST);
				IDX_HS_POLARITY: hs_pol_reg <= merge(hs_pol_reg, pwdata[7:0],
					POL_WMASK, POL_RST);
				IDX_LP_POLARITY: lp_pol_reg <= merge(lp_pol_reg, pwdata[7:0],
					POL_WMASK, POL_RST);
				IDX_SENSE_CTRL:  sense_ctrl_reg <= merge(sense_ctrl_reg, pwdata[7:0],
					SENSE_CTRL_WMASK, SENSE_CTRL_RST);
				default: ;
			endcase
		end
	end

	// Reserved bits keep their reset value and refused writes land nowhere.
	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		((hs_pol_reg | lp_pol_reg) & ~POL_WMASK) == 8'h00
		&& (return_mask_reg & ~RETURN_WMASK) == 8'h00)
		else $error("reserved bits changed");
	a_limits_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		((pin0_limits_reg | pin1_limits_reg | temp_limits_reg) & ~LIMITS_WMASK)
		== (LIMITS_RST & ~LIMITS_WMASK))
		else $error("limit reserved bits changed");
	a_mask_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		(serial_mask_reg & ~SERIAL_WMASK) == 8'h00
		&& (sensor_mask_reg & ~SENSOR_WMASK) == 8'h00)
		else $error("mask reserved bits changed");
	a_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && (pslverr || !pstrb[0])
		|=> $stable({serial_mask_reg, sensor_mask_reg, return_mask_reg, sense_ctrl_reg}))
		else $error("refused write changed a register");
	a_limits_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && word_addr[7:0] == IDX_PIN0_LIMITS
		|=> pin0_limits_reg[UPPER_LSB +: LIMIT_W] == $past(pwdata[UPPER_LSB +: LIMIT_W])
		&& pin0_limits_reg[LOWER_LSB +: LIMIT_W] == $past(pwdata[LOWER_LSB +: LIMIT_W]))
		else $error("pin0 limits write lost");

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_hit  = 1'b1;
		rd_next = 8'h00;
		if (word_addr[9:8] != 2'b00) begin
			rd_hit = 1'b0;
		end else begin
			unique case (word_addr[7:0])
				IDX_PIN0_LIMITS: rd_next = pin0_limits_reg;
				IDX_PIN1_LIMITS: rd_next = pin1_limits_reg;
				IDX_TEMP_LIMITS: rd_next = temp_limits_reg;
				IDX_SERIAL_MASK: rd_next = serial_mask_reg;
				IDX_SENSOR_MASK: rd_next = sensor_mask_reg;
				IDX_RETURN_MASK: rd_next = return_mask_reg;
				IDX_HS_POLARITY: rd_next = hs_pol_reg;
				IDX_LP_POLARITY: rd_next = lp_pol_reg;
				IDX_SENSE_CTRL:  rd_next = sense_ctrl_reg;
				IDX_SENSOR_STAT: rd_next = {2'b00, flags_reg};
				IDX_PIN0_PEAK:   rd_next = peak_reg;
				IDX_PIN0_TROUGH: rd_next = trough_reg;
				IDX_ALARM_STAT:  rd_next = {2'b00, sensor_alarm};
				default:         rd_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h00_0000, rd_next};
		end
	end

	// Read data is taken at setup and stands through the access phase.
	a_read_stands: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable
		|=> $stable(prdata))
		else $error("read data moved in access");
	a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
		prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_peak_read: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr[11:2] == {2'b00, IDX_PIN0_PEAK}
		|=> prdata[CODE_W-1:0] == $past(peak_reg))
		else $error("peak read wrong");
	a_trough_read: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr[11:2] == {2'b00, IDX_PIN0_TROUGH}
		|=> prdata[CODE_W-1:0] == $past(trough_reg))
		else $error("trough read wrong");

	// ----------------------------------------------------------------
	// Threshold comparison
	// ----------------------------------------------------------------
	// A 3-bit limit code maps to the top bits of the reading code space.
	function automatic logic [CODE_W-1:0] scale(input logic [LIMIT_W-1:0] lim);
		scale = {lim, {(CODE_W-LIMIT_W){1'b0}}};
	endfunction

	logic pin0_sel;
	logic pin1_sel;
	logic temp_en;
	assign pin0_sel = sense_ctrl_reg[SEL_PIN0_BIT];
	assign pin1_sel = sense_ctrl_reg[SEL_PIN1_BIT];
	assign temp_en  = sense_ctrl_reg[TEMP_EN_BIT];

	// Flags order: 5 temp over, 4 temp under, 3/2 pin1, 1/0 pin0.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= 6'h00;
		end else begin
			if (pin0_valid) begin
				flags_reg[1] <= pin0_sel &&
					(pin0_code > scale(pin0_limits_reg[UPPER_LSB +: LIMIT_W]));
				flags_reg[0] <= pin0_sel &&
					(pin0_code < scale(pin0_limits_reg[LOWER_LSB +: LIMIT_W]));
			end
			if (pin1_valid) begin
				flags_reg[3] <= pin1_sel &&
					(pin1_code > scale(pin1_limits_reg[UPPER_LSB +: LIMIT_W]));
				flags_reg[2] <= pin1_sel &&
					(pin1_code < scale(pin1_limits_reg[LOWER_LSB +: LIMIT_W]));
			end
			if (temp_valid) begin
				flags_reg[5] <= temp_en &&
					(temp_code > scale(temp_limits_reg[UPPER_LSB +: LIMIT_W]));
				flags_reg[4] <= temp_en &&
					(temp_code < scale(temp_limits_reg[LOWER_LSB +: LIMIT_W]));
			end
		end
	end

	// Each flag follows the last conversion of its own sensor and nothing else.
	a_pin0_over: assert property (@(posedge pclk) disable iff (!presetn)
		pin0_valid && pin0_sel && pin0_code > scale(pin0_limits_reg[UPPER_LSB +: LIMIT_W])
		|=> flags_reg[1])
		else $error("pin0 over flag missing");
	a_pin0_under: assert property (@(posedge pclk) disable iff (!presetn)
		pin0_valid && pin0_sel && pin0_code < scale(pin0_limits_reg[LOWER_LSB +: LIMIT_W])
		|=> flags_reg[0])
		else $error("pin0 under flag missing");
	a_pin0_inrange: assert property (@(posedge pclk) disable iff (!presetn)
		pin0_valid && pin0_code <= scale(pin0_limits_reg[UPPER_LSB +: LIMIT_W])
		&& pin0_code >= scale(pin0_limits_reg[LOWER_LSB +: LIMIT_W])
		|=> flags_reg[1:0] == 2'b00)
		else $error("pin0 flag inside limits");
	a_pin0_unsel: assert property (@(posedge pclk) disable iff (!presetn)
		pin0_valid && !pin0_sel
		|=> flags_reg[1:0] == 2'b00)
		else $error("pin0 flag while unselected");
	a_pin1_over: assert property (@(posedge pclk) disable iff (!presetn)
		pin1_valid && pin1_sel && pin1_code > scale(pin1_limits_reg[UPPER_LSB +: LIMIT_W])
		|=> flags_reg[3])
		else $error("pin1 over flag missing");
	a_pin1_under: assert property (@(posedge pclk) disable iff (!presetn)
		pin1_valid && pin1_sel && pin1_code < scale(pin1_limits_reg[LOWER_LSB +: LIMIT_W])
		|=> flags_reg[2])
		else $error("pin1 under flag missing");
	a_pin1_unsel: assert property (@(posedge pclk) disable iff (!presetn)
		pin1_valid && !pin1_sel
		|=> flags_reg[3:2] == 2'b00)
		else $error("pin1 flag while unselected");
	a_temp_over: assert property (@(posedge pclk) disable iff (!presetn)
		temp_valid && temp_en && temp_code > scale(temp_limits_reg[UPPER_LSB +: LIMIT_W])
		|=> flags_reg[5])
		else $error("temp over flag missing");
	a_temp_under: assert property (@(posedge pclk) disable iff (!presetn)
		temp_valid && temp_en && temp_code < scale(temp_limits_reg[LOWER_LSB +: LIMIT_W])
		|=> flags_reg[4])
		else $error("temp under flag missing");
	a_temp_off: assert property (@(posedge pclk) disable iff (!presetn)
		temp_valid && !temp_en
		|=> flags_reg[5:4] == 2'b00)
		else $error("temp flag while disabled");
	a_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!pin0_valid && !pin1_valid && !temp_valid
		|=> $stable(flags_reg))
		else $error("flags moved without conversion");

	// Peak and trough track only while pin 0 is sensed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peak_reg   <= '0;
			trough_reg <= CODE_MAX;
		end else if (pin0_valid && pin0_sel) begin
			if (pin0_code > peak_reg) begin
				peak_reg <= pin0_code;
			end
			if (pin0_code < trough_reg) begin
				trough_reg <= pin0_code;
			end
		end
	end

	// Extremes only widen, and only on a sensed pin 0 conversion.
	a_peak_tracks: assert property (@(posedge pclk) disable iff (!presetn)
		pin0_valid && pin0_sel
		|=> peak_reg >= $past(pin0_code))
		else $error("peak below reading");
	a_trough_tracks: assert property (@(posedge pclk) disable iff (!presetn)
		pin0_valid && pin0_sel
		|=> trough_reg <= $past(pin0_code))
		else $error("trough above reading");
	a_peak_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(pin0_valid && pin0_sel)
		|=> $stable(peak_reg) && $stable(trough_reg))
		else $error("extremes moved while idle");
	a_peak_monotone: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1
		|=> peak_reg >= $past(peak_reg) && trough_reg <= $past(trough_reg))
		else $error("extremes moved backwards");

	// ----------------------------------------------------------------
	// Alarm gating
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_alarm <= '0;
			sensor_alarm <= '0;
			return_alarm <= '0;
		end else begin
			serial_alarm <= serial_cond
				& serial_mask_reg[SERIAL_ALARMS-1:0];
			sensor_alarm <= flags_reg & sensor_mask_reg[SENSOR_ALARMS-1:0];
			return_alarm <= return_cond & return_mask_reg[RETURN_ALARMS-1:0];
		end
	end

	// Every alarm is its condition of one cycle ago under its mask bit.
	a_sensor_gate: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1
		|=> sensor_alarm == ($past(flags_reg) & $past(sensor_mask_reg[SENSOR_ALARMS-1:0])))
		else $error("sensor alarm not gated");
	a_serial_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!serial_mask_reg[5]
		|=> !serial_alarm[5])
		else $error("frame alarm while masked");
	a_serial_all: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1
		|=> serial_alarm == ($past(serial_cond) & $past(serial_mask_reg[SERIAL_ALARMS-1:0])))
		else $error("serial alarm not gated");
	a_return_gate: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1
		|=> return_alarm == ($past(return_cond) & $past(return_mask_reg[RETURN_ALARMS-1:0])))
		else $error("return alarm not gated");

	// ----------------------------------------------------------------
	// Lane polarity
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g <= LANES; g++) begin : g_lane
			assign hs_lane_out[g] = hs_lane_in[g] ^ hs_pol_reg[g];
			assign lp_lane_out[g] = lp_lane_in[g] ^ lp_pol_reg[g];
		end
	endgenerate

	// The clock lane follows its input with the selected sense.
	a_hs_polarity: assert property (@(posedge pclk) disable iff (!presetn)
		hs_lane_out[CLK_LANE_BIT]
		== (hs_lane_in[CLK_LANE_BIT] ^ hs_pol_reg[CLK_LANE_BIT]))
		else $error("clock lane polarity wrong");

endmodule

// File: hw/alarm_cfg_pkg.sv
// Notes on behaviour
// - Pin0 reading above upper limit sets over flag
// - Pin0 reading below lower limit sets under flag
// - Keep highest pin0 reading, host readable
// - Keep lowest pin0 reading, host readable
// - Pin1 upper limit raises pin1 over status
// - Pin1 lower limit raises pin1 under status
// - Enabled temperature above upper limit sets flag
// - Enabled temperature below lower limit sets flag
// - Serial mask bit5 enables missing frame alarm
// - Bits 4,3 enable lane sync, control alarms
// - Bit2 enables header double-bit ECC alarm
// - Bit1 enables payload checksum alarm
// - Bit0 enables packet length alarm
// - Sensor mask bits 5,4 temperature alarms
// - Sensor mask bits 3,2 pin1 alarms
// - Sensor mask bits 1,0 pin0 alarms
// - Return mask bits 1,0 CRC, link detect
// - Per-lane high-speed polarity inversion bits
// - Separate low-power polarity inversion control
// - Two-bit selector picks voltage-sensed pins
package alarm_cfg_pkg;

	// ----------------------------------------------------------------
	// Register indices; the byte address is four times the index.
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_PIN0_LIMITS  = 8'h19;
	localparam logic [7:0] IDX_PIN1_LIMITS  = 8'h1a;
	localparam logic [7:0] IDX_TEMP_LIMITS  = 8'h1b;
	localparam logic [7:0] IDX_SERIAL_MASK  = 8'h1c;
	localparam logic [7:0] IDX_SENSOR_MASK  = 8'h1d;
	localparam logic [7:0] IDX_RETURN_MASK  = 8'h1e;
	localparam logic [7:0] IDX_HS_POLARITY  = 8'h20;
	localparam logic [7:0] IDX_LP_POLARITY  = 8'h21;
	localparam logic [7:0] IDX_SENSE_CTRL   = 8'h17;
	localparam logic [7:0] IDX_SENSOR_STAT  = 8'h40;
	localparam logic [7:0] IDX_PIN0_PEAK    = 8'h41;
	localparam logic [7:0] IDX_PIN0_TROUGH  = 8'h42;
	localparam logic [7:0] IDX_ALARM_STAT   = 8'h43;

	// ----------------------------------------------------------------
	// Field layouts and reset values
	// ----------------------------------------------------------------
	localparam int UPPER_LSB = 4;
	localparam int LOWER_LSB = 0;
	localparam int LIMIT_W   = 3;
	localparam int CODE_W    = 8;
	localparam logic [7:0] LIMITS_RST      = 8'h62;
	localparam logic [7:0] LIMITS_WMASK    = 8'h77;
	localparam logic [7:0] SERIAL_MASK_RST = 8'h3f;
	localparam logic [7:0] SERIAL_WMASK    = 8'h3f;
	localparam logic [7:0] SENSOR_MASK_RST = 8'h00;
	localparam logic [7:0] SENSOR_WMASK    = 8'h3f;
	localparam logic [7:0] RETURN_MASK_RST = 8'h00;
	localparam logic [7:0] RETURN_WMASK    = 8'h03;
	localparam logic [7:0] POL_RST         = 8'h00;
	localparam logic [7:0] POL_WMASK       = 8'h1f;
	localparam logic [7:0] SENSE_CTRL_RST  = 8'h3c;
	localparam logic [7:0] SENSE_CTRL_WMASK = 8'hff;
	localparam int SEL_PIN0_BIT  = 0;
	localparam int SEL_PIN1_BIT  = 1;
	localparam int TEMP_EN_BIT   = 2;
	localparam int CLK_LANE_BIT  = 4;
	localparam int LANES         = 4;
	localparam int SERIAL_ALARMS = 6;
	localparam int SENSOR_ALARMS = 6;
	localparam int RETURN_ALARMS = 2;
	localparam logic [7:0] CODE_MAX = 8'hff;

endpackage

// File: verification/sensor_source.sv
`timescale 1ns/1ps
// ----
// Conversion result source
// ----
module sensor_source (
	// Clock
	input  wire logic       pclk,
	// Conversion result
	output logic            valid,
	output logic      [7:0] code
);
	initial begin
		valid = 1'b0;
		code  = 8'h00;
	end

	// One result a pulse; outside it the code shows its inverse.
	task automatic send(input logic [7:0] c);
		valid <= 1'b1;
		code  <= c;
		@(posedge pclk);
		valid <= 1'b0;
		code  <= ~c;
	endtask
endmodule

// File: verification/sensor_threshold_alarm_config_tb.sv
`timescale 1ns/1ps
module sensor_threshold_alarm_config_tb;
	import alarm_cfg_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  pstrb;
	logic        v0, v1, vt;
	logic [7:0]  c0, c1, ct;
	logic [5:0]  scond, salm, nalm;
	logic [1:0]  rcond, ralm;
	logic [4:0]  hsi, lpi, hso, lpo;
	int          n_errors, checks_done, cyc;

	sensor_threshold_alarm_config dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin0_valid(v0),
		.pin0_code(c0), .pin1_valid(v1), .pin1_code(c1), .temp_valid(vt), .temp_code(ct),
		.serial_cond(scond), .return_cond(rcond), .serial_alarm(salm),
		.sensor_alarm(nalm), .return_alarm(ralm), .hs_lane_in(hsi), .lp_lane_in(lpi),
		.hs_lane_out(hso), .lp_lane_out(lpo));
	sensor_source s0 (.pclk(pclk), .valid(v0), .code(c0));
	sensor_source s1 (.pclk(pclk), .valid(v1), .code(c1));
	sensor_source s2 (.pclk(pclk), .valid(vt), .code(ct));

	// ----
	// Helpers
	// ----
	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
			input logic [3:0] s);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad(i);
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, i, {24'h0, d}, 4'hf);
	endtask

	task automatic rdc(input string nm, input logic [7:0] i, input logic [7:0] e);
		apb(1'b0, i, 32'h0, 4'h0);
		chk(nm, {24'h0, e}, rdat);
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		logic [7:0] a[9] = '{IDX_PIN0_LIMITS, IDX_PIN1_LIMITS, IDX_TEMP_LIMITS,
			IDX_SERIAL_MASK, IDX_SENSOR_MASK, IDX_RETURN_MASK, IDX_HS_POLARITY,
			IDX_LP_POLARITY, IDX_SENSE_CTRL};
		logic [7:0] rv[9] = '{8'h62, 8'h62, 8'h62, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3c};
		logic [7:0] wv[9] = '{8'h77, 8'h77, 8'h77, 8'h3f, 8'h3f, 8'h03, 8'h1f, 8'h1f, 8'hff};
		for (int k = 0; k < 9; k++) begin
			rdc("reset value", a[k], rv[k]);
			wr(a[k], 8'hff);
			rdc("reserved bits", a[k], wv[k]);
			wr(a[k], rv[k]);
		end
		apb(1'b1, IDX_SERIAL_MASK, 32'h0, 4'h0);
		rdc("no strobe write", IDX_SERIAL_MASK, 8'h3f);
		apb(1'b0, 8'hff, 32'h0, 4'h0);
		chk("unmapped read", 32'h0, rdat);
		chk("unmapped error", 32'h1, {31'h0, rerr});
	endtask

	task automatic t_masks();
		scond <= 6'h3f;
		rcond <= 2'h3;
		repeat (3) @(posedge pclk);
		chk("serial default", 32'h3f, {26'h0, salm});
		chk("return default", 32'h0, {30'h0, ralm});
		for (int k = 0; k < 6; k++) begin
			wr(IDX_SERIAL_MASK, 8'h01 << k);
			if (k < 2) wr(IDX_RETURN_MASK, 8'h01 << k);
			repeat (2) @(posedge pclk);
			chk("serial alarm", 32'h1 << k, {26'h0, salm});
			if (k < 2) chk("return alarm", 32'h1 << k, {30'h0, ralm});
		end
	endtask

	task automatic t_polarity();
		hsi <= 5'h0a;
		lpi <= 5'h13;
		wr(IDX_HS_POLARITY, 8'h11);
		wr(IDX_LP_POLARITY, 8'h0e);
		@(posedge pclk);
		chk("hs lanes", 32'h1b, {27'h0, hso});
		chk("lp lanes", 32'h1d, {27'h0, lpo});
	endtask

	task automatic send(input int ch, input logic [7:0] c);
		case (ch)
			0: s0.send(c);
			1: s1.send(c);
			default: s2.send(c);
		endcase
		repeat (3) @(posedge pclk);
	endtask

	task automatic t_sensors();
		int         ch[7] = '{0, 0, 0, 0, 1, 2, 2};
		logic [7:0] cd[7] = '{8'hc0, 8'hc1, 8'h3f, 8'h40, 8'hc1, 8'h3f, 8'hc1};
		logic [7:0] st[7] = '{8'h00, 8'h02, 8'h01, 8'h00, 8'h08, 8'h18, 8'h28};
		wr(IDX_SENSE_CTRL, 8'h07);
		wr(IDX_SENSOR_MASK, 8'h3f);
		for (int k = 0; k < 7; k++) begin
			send(ch[k], cd[k]);
			chk("sensor alarm", {24'h0, st[k]}, {26'h0, nalm});
			rdc("sensor flags", IDX_SENSOR_STAT, st[k]);
		end
		rdc("pin0 peak", IDX_PIN0_PEAK, 8'hc1);
		rdc("pin0 trough", IDX_PIN0_TROUGH, 8'h3f);
		wr(IDX_SENSE_CTRL, 8'h06);
		send(0, 8'hff);
		rdc("unselected peak", IDX_PIN0_PEAK, 8'hc1);
		wr(IDX_SENSOR_MASK, 8'h10);
		repeat (2) @(posedge pclk);
		chk("masked alarm", 32'h0, {26'h0, nalm});
		rdc("alarm reg", IDX_ALARM_STAT, 8'h00);
		wr(IDX_SENSE_CTRL, 8'h01);
		send(1, 8'hc1);
		send(2, 8'hc1);
		rdc("unselected flags", IDX_SENSOR_STAT, 8'h00);
	endtask

	// ----
	// Clock, timeout and main sequence
	// ----
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{scond, rcond, hsi, lpi, n_errors, checks_done, cyc} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_masks();
		t_polarity();
		t_sensors();
		stop_test();
	end
endmodule
